// *** core/aicm_pkg.sv ***
// Purpose: Shared types, offsets and reset values of the analog input curve mapper.
// Assumes: Voltages in 0.01 V steps, settings in 0.1 % steps, both signed 16-bit.
// Notes:   Register offsets are byte addresses on a 32-bit AHB-Lite slave.
package aicm_pkg;

    typedef logic signed [15:0] aicm_val_t;

    typedef struct packed {
        aicm_val_t pct;
        aicm_val_t volt;
    } aicm_pt_s;

    typedef struct packed {
        aicm_val_t band;
        aicm_val_t point;
    } aicm_jump_s;

    typedef aicm_pt_s [3:0] aicm_curve_t;

    typedef enum logic [2:0] {
        AICM_LINE_ONE,
        AICM_LINE_TWO,
        AICM_LINE_THREE,
        AICM_MULTI_A,
        AICM_MULTI_B
    } aicm_curve_e;

    localparam int NUM_IN    = 3;
    localparam int NUM_MULTI = 2;
    localparam int ADDR_W    = 8;
    localparam int SEL_W     = 3;

    // Value ranges
    localparam aicm_val_t V_LO    = 16'hfc18;
    localparam aicm_val_t V_HI    = 16'h03e8;
    localparam aicm_val_t P_LO    = 16'hfc18;
    localparam aicm_val_t P_HI    = 16'h03e8;
    localparam aicm_val_t BAND_LO = 16'h0000;

    // Reset values of both multi-point curves
    localparam aicm_val_t V_MIN_RST  = 16'h0000;
    localparam aicm_val_t V_INF1_RST = 16'h012c;
    localparam aicm_val_t V_INF2_RST = 16'h0258;
    localparam aicm_val_t V_MAX_RST  = 16'h03e8;
    localparam aicm_val_t P_MIN_RST  = 16'h0000;
    localparam aicm_val_t P_INF1_RST = 16'h012c;
    localparam aicm_val_t P_INF2_RST = 16'h0258;
    localparam aicm_val_t P_MAX_RST  = 16'h03e8;
    localparam aicm_curve_t CURVE_RST = {P_MAX_RST, V_MAX_RST, P_INF2_RST, V_INF2_RST,
                                         P_INF1_RST, V_INF1_RST, P_MIN_RST, V_MIN_RST};

    localparam aicm_val_t JUMP_POINT_RST = 16'h0000;
    localparam aicm_val_t JUMP_BAND_RST  = 16'h0005;
    localparam aicm_jump_s JUMP_RST      = {JUMP_BAND_RST, JUMP_POINT_RST};

    // Fixed end points shared by the three straight-line curves
    localparam aicm_val_t LINE_V_LO = 16'h0000;
    localparam aicm_val_t LINE_V_HI = 16'h03e8;
    localparam aicm_val_t LINE_P_LO = 16'h0000;
    localparam aicm_val_t LINE_P_HI = 16'h03e8;

    localparam logic [8:0] SEL_RST = 9'h000;

    // Register map
    localparam logic [7:0] ADDR_SEL        = 8'h00;
    localparam logic [3:0] CURVE_A_PAGE    = 4'h1;
    localparam logic [3:0] CURVE_B_PAGE    = 4'h2;
    localparam logic [3:0] JUMP_PAGE       = 4'h3;
    localparam logic [3:0] SETTING_PAGE    = 4'h4;
    localparam logic [2:0] HSIZE_WORD      = 3'h2;

    function automatic aicm_val_t sat(input aicm_val_t v, input aicm_val_t lo,
                                      input aicm_val_t hi);
        if (v < lo)
        begin
            return lo;
        end
        if (v > hi)
        begin
            return hi;
        end
        return v;
    endfunction

endpackage

// *** core/aicm_curve_eval.sv ***
// Purpose: Evaluates one four-point piecewise-linear curve for one sample.
// Assumes: Breakpoint voltages non-decreasing; equal neighbours collapse a segment.
// Notes:   Purely combinational; the caller registers the result.
`timescale 1ns/10ps
`default_nettype none

module aicm_curve_eval (
    input  wire aicm_pkg::aicm_val_t   sample,
    input  wire aicm_pkg::aicm_curve_t pts,
    output aicm_pkg::aicm_val_t        pct
);

    logic [1:0]         seg;
    aicm_pkg::aicm_pt_s lo_pt;
    aicm_pkg::aicm_pt_s hi_pt;
    logic signed [16:0] dx;
    logic signed [16:0] dp;
    logic signed [16:0] dv;
    logic signed [33:0] prod;
    logic signed [33:0] quot;

    always_comb
    begin
        seg = 2'd0;
        if (sample >= pts[2].volt)
        begin
            seg = 2'd2;
        end
        else if (sample >= pts[1].volt)
        begin
            seg = 2'd1;
        end
        lo_pt = pts[seg];
        hi_pt = pts[seg + 2'd1];
        dx    = {sample[15], sample} - {lo_pt.volt[15], lo_pt.volt};
        dp    = {hi_pt.pct[15], hi_pt.pct} - {lo_pt.pct[15], lo_pt.pct};
        dv    = {hi_pt.volt[15], hi_pt.volt} - {lo_pt.volt[15], lo_pt.volt};
        prod  = 34'(dx) * 34'(dp);
        // A collapsed segment would divide by zero; hold its lower output
        quot  = (dv > 17'sd0) ? prod / 34'(dv) : 34'sd0;
        if (sample <= pts[0].volt)
        begin
            pct = pts[0].pct;
        end
        else if (sample >= pts[3].volt)
        begin
            pct = pts[3].pct;
        end
        else
        begin
            pct = lo_pt.pct + aicm_pkg::aicm_val_t'(quot[15:0]);
        end
    end

endmodule

`default_nettype wire

// *** core/aicm_mapper_top.sv ***
// Purpose: Maps three analog samples through selectable curves and a jump band.
// Assumes: Samples arrive with sample_valid, synchronous to hclk; AHB-Lite slave.
// Notes:   Zero-wait-state slave; reads see a write made in the cycle before.
// Contract
// - Two four-breakpoint curves, voltage/percent pairs each.
// - Voltages -10..10 V, percents -100..100 %.
// - First curve resets to 0/3/6/10 V points.
// - Second curve stored separately, same ranges, defaults.
// - Each input picks one of five curves.
// - Curve selection decides each input's conversion.
// - Inside jump band, output forced to jump point.
// - Per-input jump point, +-100 %, resets 0 %.
// - Per-input jump band, 0..100 %, resets 0.5 %.
// - Third input has same jump settings, defaults.
//
// Chosen here: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

module aicm_mapper_top (
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic                     hreadyout,
    output logic [31:0]              hrdata,
    output logic                     hresp,
    input  wire logic                sample_valid,
    input  wire aicm_pkg::aicm_val_t analog_input_one,
    input  wire aicm_pkg::aicm_val_t analog_input_two,
    input  wire aicm_pkg::aicm_val_t analog_input_three,
    output aicm_pkg::aicm_val_t      setting_one,
    output aicm_pkg::aicm_val_t      setting_two,
    output aicm_pkg::aicm_val_t      setting_three,
    output logic                     setting_valid
);

    logic                  addr_ok;
    logic                  dp_wr_r;
    logic                  dp_wr_nxt;
    logic [7:0]            dp_addr_r;
    logic [7:0]            dp_addr_nxt;
    logic [31:0]           rdata_r;
    logic [31:0]           rdata_nxt;
    logic [8:0]            sel_r;
    logic [8:0]            sel_nxt;
    aicm_pkg::aicm_curve_t curve_r   [aicm_pkg::NUM_MULTI];
    aicm_pkg::aicm_curve_t curve_nxt [aicm_pkg::NUM_MULTI];
    aicm_pkg::aicm_jump_s  jump_r    [aicm_pkg::NUM_IN];
    aicm_pkg::aicm_jump_s  jump_nxt  [aicm_pkg::NUM_IN];
    aicm_pkg::aicm_val_t   raw_r     [aicm_pkg::NUM_IN];
    aicm_pkg::aicm_val_t   raw_nxt   [aicm_pkg::NUM_IN];
    aicm_pkg::aicm_val_t   set_r     [aicm_pkg::NUM_IN];
    aicm_pkg::aicm_val_t   set_nxt   [aicm_pkg::NUM_IN];
    aicm_pkg::aicm_val_t   samp      [aicm_pkg::NUM_IN];
    aicm_pkg::aicm_curve_t pick      [aicm_pkg::NUM_IN];
    aicm_pkg::aicm_val_t   mapped    [aicm_pkg::NUM_IN];
    logic [aicm_pkg::NUM_IN-1:0] hit;
    logic                  valid_r;

    function automatic logic is_curve(input logic [7:0] a);
        return (a[7:4] == aicm_pkg::CURVE_A_PAGE || a[7:4] == aicm_pkg::CURVE_B_PAGE)
               && a[1:0] == 2'b00;
    endfunction

    function automatic logic is_idx3(input logic [7:0] a, input logic [3:0] page);
        return a[7:4] == page && a[3:2] != 2'b11 && a[1:0] == 2'b00;
    endfunction

    function automatic logic jump_hit(input aicm_pkg::aicm_val_t v,
                                      input aicm_pkg::aicm_jump_s j);
        logic signed [16:0] d;
        d = {v[15], v} - {j.point[15], j.point};
        if (d < 17'sd0)
        begin
            d = -d;
        end
        return d <= {1'b0, j.band};
    endfunction

    function automatic aicm_pkg::aicm_curve_t line_pts();
        return {aicm_pkg::LINE_P_HI, aicm_pkg::LINE_V_HI, aicm_pkg::LINE_P_HI,
                aicm_pkg::LINE_V_HI, aicm_pkg::LINE_P_LO, aicm_pkg::LINE_V_LO,
                aicm_pkg::LINE_P_LO, aicm_pkg::LINE_V_LO};
    endfunction

    // Bus address phase; only whole-word transfers change state
    always_comb
    begin
        addr_ok     = hsel && hready && htrans[1] && (haddr[31:aicm_pkg::ADDR_W] == 24'h0);
        dp_wr_nxt   = addr_ok && hwrite && (hsize == aicm_pkg::HSIZE_WORD);
        dp_addr_nxt = addr_ok ? haddr[7:0] : dp_addr_r;
    end

    // Register writes land at the end of the data phase
    always_comb
    begin
        sel_nxt = sel_r;
        for (int c = 0; c < aicm_pkg::NUM_MULTI; c++)
        begin
            curve_nxt[c] = curve_r[c];
        end
        for (int i = 0; i < aicm_pkg::NUM_IN; i++)
        begin
            jump_nxt[i] = jump_r[i];
        end
        if (dp_wr_r)
        begin
            if (dp_addr_r == aicm_pkg::ADDR_SEL)
            begin
                for (int i = 0; i < aicm_pkg::NUM_IN; i++)
                begin
                    // Codes above the last curve are dropped, keeping the old choice
                    if (hwdata[i*3 +: 3] <= 3'(aicm_pkg::AICM_MULTI_B))
                    begin
                        sel_nxt[i*3 +: 3] = hwdata[i*3 +: 3];
                    end
                end
            end
            if (is_curve(dp_addr_r))
            begin
                curve_nxt[dp_addr_r[5]][dp_addr_r[3:2]] =
                    {aicm_pkg::sat(hwdata[31:16], aicm_pkg::P_LO, aicm_pkg::P_HI),
                     aicm_pkg::sat(hwdata[15:0], aicm_pkg::V_LO, aicm_pkg::V_HI)};
            end
            if (is_idx3(dp_addr_r, aicm_pkg::JUMP_PAGE))
            begin
                jump_nxt[dp_addr_r[3:2]] =
                    {aicm_pkg::sat(hwdata[31:16], aicm_pkg::BAND_LO, aicm_pkg::P_HI),
                     aicm_pkg::sat(hwdata[15:0], aicm_pkg::P_LO, aicm_pkg::P_HI)};
            end
        end
    end

    // Read data taken from next values so a read right after a write sees it
    always_comb
    begin
        rdata_nxt = rdata_r;
        if (addr_ok && !hwrite)
        begin
            rdata_nxt = 32'h0;
            if (haddr[7:0] == aicm_pkg::ADDR_SEL)
            begin
                rdata_nxt = {23'h0, sel_nxt};
            end
            else if (is_curve(haddr[7:0]))
            begin
                rdata_nxt = curve_nxt[haddr[5]][haddr[3:2]];
            end
            else if (is_idx3(haddr[7:0], aicm_pkg::JUMP_PAGE))
            begin
                rdata_nxt = jump_nxt[haddr[3:2]];
            end
            else if (is_idx3(haddr[7:0], aicm_pkg::SETTING_PAGE))
            begin
                rdata_nxt = {raw_r[haddr[3:2]], set_r[haddr[3:2]]};
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_wr_r   <= 1'b0;
            dp_addr_r <= 8'h00;
            rdata_r   <= 32'h0;
            sel_r     <= aicm_pkg::SEL_RST;
            for (int c = 0; c < aicm_pkg::NUM_MULTI; c++)
            begin
                curve_r[c] <= aicm_pkg::CURVE_RST;
            end
            for (int i = 0; i < aicm_pkg::NUM_IN; i++)
            begin
                jump_r[i] <= aicm_pkg::JUMP_RST;
            end
        end
        else
        begin
            dp_wr_r   <= dp_wr_nxt;
            dp_addr_r <= dp_addr_nxt;
            rdata_r   <= rdata_nxt;
            sel_r     <= sel_nxt;
            curve_r   <= curve_nxt;
            jump_r    <= jump_nxt;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_r;

    assign samp[0] = analog_input_one;
    assign samp[1] = analog_input_two;
    assign samp[2] = analog_input_three;

    always_comb
    begin
        for (int i = 0; i < aicm_pkg::NUM_IN; i++)
        begin
            case (aicm_pkg::aicm_curve_e'(sel_r[i*3 +: 3]))
                aicm_pkg::AICM_MULTI_A: pick[i] = curve_r[0];
                aicm_pkg::AICM_MULTI_B: pick[i] = curve_r[1];
                default:                pick[i] = line_pts();
            endcase
        end
    end

    for (genvar g = 0; g < aicm_pkg::NUM_IN; g++)
    begin : g_eval
        aicm_curve_eval u_eval (
            .sample (samp[g]),
            .pts    (pick[g]),
            .pct    (mapped[g])
        );
    end

    always_comb
    begin
        for (int i = 0; i < aicm_pkg::NUM_IN; i++)
        begin
            hit[i]     = sample_valid && jump_hit(mapped[i], jump_r[i]);
            raw_nxt[i] = sample_valid ? mapped[i] : raw_r[i];
            set_nxt[i] = set_r[i];
            if (sample_valid)
            begin
                set_nxt[i] = hit[i] ? jump_r[i].point : mapped[i];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            valid_r <= 1'b0;
            for (int i = 0; i < aicm_pkg::NUM_IN; i++)
            begin
                raw_r[i] <= 16'h0000;
                set_r[i] <= 16'h0000;
            end
        end
        else
        begin
            valid_r <= sample_valid;
            raw_r   <= raw_nxt;
            set_r   <= set_nxt;
        end
    end

    assign setting_one   = set_r[0];
    assign setting_two   = set_r[1];
    assign setting_three = set_r[2];
    assign setting_valid = valid_r;

    // Helper state read only by the checks below
    logic                seen_r;
    logic                range_ok;
    logic                pass0;
    logic                clamp_a0;
    logic                knee_a0;
    aicm_pkg::aicm_val_t jp0;
    aicm_pkg::aicm_val_t map0;
    aicm_pkg::aicm_val_t a_p0;
    aicm_pkg::aicm_val_t a_p1;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            seen_r <= 1'b0;
        end
        else
        begin
            seen_r <= 1'b1;
        end
    end

    always_comb
    begin
        range_ok = 1'b1;
        for (int c = 0; c < aicm_pkg::NUM_MULTI; c++)
        begin
            for (int k = 0; k < 4; k++)
            begin
                if (curve_r[c][k].volt < aicm_pkg::V_LO || curve_r[c][k].volt > aicm_pkg::V_HI
                    || curve_r[c][k].pct < aicm_pkg::P_LO || curve_r[c][k].pct > aicm_pkg::P_HI)
                begin
                    range_ok = 1'b0;
                end
            end
        end
        for (int i = 0; i < aicm_pkg::NUM_IN; i++)
        begin
            if (jump_r[i].band < aicm_pkg::BAND_LO || jump_r[i].band > aicm_pkg::P_HI)
            begin
                range_ok = 1'b0;
            end
        end
    end

    assign jp0      = jump_r[0].point;
    assign map0     = mapped[0];
    assign a_p0     = curve_r[0][0].pct;
    assign a_p1     = curve_r[0][1].pct;
    assign pass0    = sample_valid && !hit[0];
    assign clamp_a0 = sample_valid && sel_r[2:0] == 3'(aicm_pkg::AICM_MULTI_A)
                      && analog_input_one <= curve_r[0][0].volt;
    assign knee_a0  = sample_valid && sel_r[2:0] == 3'(aicm_pkg::AICM_MULTI_A)
                      && analog_input_one == curve_r[0][1].volt
                      && curve_r[0][0].volt < curve_r[0][1].volt
                      && curve_r[0][1].volt < curve_r[0][2].volt;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    AST_KNEE_EXACT: assert property (knee_a0 |=> raw_r[0] == $past(a_p1))
        else $error("Inflexion sample did not map to its percent");
    AST_STORED_RANGE: assert property (range_ok)
        else $error("Stored breakpoint or band out of range");
    AST_RST_CURVE_A: assert property (!seen_r |-> curve_r[0] == aicm_pkg::CURVE_RST)
        else $error("First curve not at reset defaults");
    AST_RST_CURVE_B: assert property (!seen_r |-> curve_r[1] == aicm_pkg::CURVE_RST)
        else $error("Second curve not at reset defaults");
    AST_VALID_FOLLOWS: assert property (setting_valid == $past(sample_valid))
        else $error("Setting strobe not one cycle after sample");
    AST_SEL_BY_WRITE: assert property ($changed(sel_r) |-> $past(dp_wr_r)
                                       && $past(dp_addr_r) == aicm_pkg::ADDR_SEL)
        else $error("Curve selection changed without a write");
    AST_JUMP_HOLD: assert property (hit[0] |=> setting_one == $past(jp0))
        else $error("In-band sample not held at jump point");
    AST_RST_POINT: assert property (!seen_r |-> jump_r[0].point == aicm_pkg::JUMP_POINT_RST
                                    && jump_r[1].point == aicm_pkg::JUMP_POINT_RST)
        else $error("Jump point not at reset default");
    AST_RST_BAND: assert property (!seen_r |-> jump_r[0].band == aicm_pkg::JUMP_BAND_RST
                                   && jump_r[1].band == aicm_pkg::JUMP_BAND_RST)
        else $error("Jump band not at reset default");
    AST_RST_THIRD: assert property (!seen_r |-> jump_r[2] == aicm_pkg::JUMP_RST)
        else $error("Third input jump settings not at defaults");
    AST_CLAMP_LOW: assert property (clamp_a0 |=> raw_r[0] == $past(a_p0))
        else $error("Sample below first breakpoint not clamped");
    AST_PASS_OUT: assert property (pass0 |=> setting_one == $past(map0))
        else $error("Out-of-band sample altered");

    COV_HOLD: cover property (hit[0] ##1 setting_valid);
    COV_SEL_WRITE: cover property (dp_wr_r && dp_addr_r == aicm_pkg::ADDR_SEL);
    COV_MULTI_B: cover property (sample_valid && sel_r[8:6] == 3'(aicm_pkg::AICM_MULTI_B));
    COV_CLAMP: cover property (clamp_a0);

endmodule

`default_nettype wire

// *** sim/aicm_front_model.sv ***
// Purpose: Analog sampling front end and setting consumer for the mapper.
// Assumes: One sample in flight; send is entered just after a rising edge.
// Notes:   Between samples the inputs show the inverse of the last value.
`timescale 1ns/10ps
`default_nettype none

module aicm_front_model (
    input  wire logic                hclk,
    output logic                     sample_valid,
    output aicm_pkg::aicm_val_t      a1,
    output aicm_pkg::aicm_val_t      a2,
    output aicm_pkg::aicm_val_t      a3,
    input  wire aicm_pkg::aicm_val_t s1,
    input  wire aicm_pkg::aicm_val_t s2,
    input  wire aicm_pkg::aicm_val_t s3,
    input  wire logic                sv
);
    aicm_pkg::aicm_val_t got [3];
    logic                ok;

    initial
    begin
        sample_valid = 1'b0;
        a1 = 16'h0000;
        a2 = 16'h0000;
        a3 = 16'h0000;
    end

    task automatic send(input aicm_pkg::aicm_val_t x1, x2, x3);
        int n;
        n = 0;
        ok = 1'b0;
        @(posedge hclk);
        sample_valid <= 1'b1;
        a1 <= x1;
        a2 <= x2;
        a3 <= x3;
        @(posedge hclk);
        // Stale levels must not pose as a fresh sample
        sample_valid <= 1'b0;
        a1 <= ~x1;
        a2 <= ~x2;
        a3 <= ~x3;
        while (!ok && n < 4)
        begin
            @(posedge hclk);
            n++;
            if (sv === 1'b1)
            begin
                ok = 1'b1;
                got = '{s1, s2, s3};
            end
        end
    endtask
endmodule

`default_nettype wire

// *** sim/tb.sv ***
// Purpose: Self-checking bench for the analog input curve mapper.
// Assumes: Zero-wait AHB-Lite slave; settings one cycle after a sample.
// Notes:   Expected values come from a local model of the curves.
`timescale 1ns/10ps
`default_nettype none

module tb;
    logic                hclk;
    logic                hresetn;
    logic                hsel;
    logic [31:0]         haddr;
    logic [1:0]          htrans;
    logic                hwrite;
    logic [2:0]          hsize;
    logic [31:0]         hwdata;
    logic                hreadyout;
    logic [31:0]         hrdata;
    logic                hresp;
    logic                sample_valid;
    logic                setting_valid;
    aicm_pkg::aicm_val_t a1;
    aicm_pkg::aicm_val_t a2;
    aicm_pkg::aicm_val_t a3;
    aicm_pkg::aicm_val_t s1;
    aicm_pkg::aicm_val_t s2;
    aicm_pkg::aicm_val_t s3;
    int                  bad_count;
    int                  checks;
    int                  av[4];
    int                  ap[4];
    int                  bv[4];
    int                  bp[4];

    aicm_mapper_top dut (
        .hclk              (hclk),
        .hresetn           (hresetn),
        .hsel              (hsel),
        .haddr             (haddr),
        .htrans            (htrans),
        .hwrite            (hwrite),
        .hsize             (hsize),
        .hwdata            (hwdata),
        .hready            (hreadyout),
        .hreadyout         (hreadyout),
        .hrdata            (hrdata),
        .hresp             (hresp),
        .sample_valid      (sample_valid),
        .analog_input_one  (a1),
        .analog_input_two  (a2),
        .analog_input_three(a3),
        .setting_one       (s1),
        .setting_two       (s2),
        .setting_three     (s3),
        .setting_valid     (setting_valid)
    );

    aicm_front_model fe (
        .hclk        (hclk),
        .sample_valid(sample_valid),
        .a1          (a1),
        .a2          (a2),
        .a3          (a3),
        .s1          (s1),
        .s2          (s2),
        .s3          (s3),
        .sv          (setting_valid)
    );

    initial
    begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    task automatic close_out();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
        begin
            n++;
            if (n > 16)
            begin
                bad_count++;
                close_out();
            end
            @(posedge hclk);
        end
    endtask

    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h000000, a};
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        ahb(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        ahb(1'b0, a, 32'h00000000, q);
        check(q, exp);
    endtask

    function automatic int interp(input int v[4], input int p[4], input int x);
        if (x <= v[0])
            return p[0];
        for (int k = 0; k < 3; k++)
            if (x < v[k+1])
                return p[k] + (x - v[k]) * (p[k+1] - p[k]) / (v[k+1] - v[k]);
        return p[3];
    endfunction

    function automatic int jmp(input int m, input int pt, input int bd);
        return (m - pt <= bd && pt - m <= bd) ? pt : m;
    endfunction

    task automatic smp(input int x1, x2, x3, e1, e2, e3);
        fe.send(16'(x1), 16'(x2), 16'(x3));
        if (fe.ok !== 1'b1)
        begin
            bad_count++;
            close_out();
        end
        check(fe.got[0], e1);
        check(fe.got[1], e2);
        check(fe.got[2], e3);
    endtask

    task automatic t_reset();
        int r[4] = '{0, 300, 600, 1000};
        for (int i = 0; i < 8; i++)
            rd(8'h10 + 8'(4 * i), {16'(r[i % 4]), 16'(r[i % 4])});
        for (int i = 0; i < 3; i++)
            rd(8'h30 + 8'(4 * i), 32'h00050000);
        rd(8'h00, 32'h00000000);
        rd(8'h60, 32'h00000000);
    endtask

    task automatic t_line();
        smp(500, 3, 6, 500, 0, 6);
        smp(1000, -1000, 5, 1000, 0, 0);
    endtask

    task automatic t_curves();
        av = '{-1000, -200, 400, 900};
        ap = '{-1000, 100, 700, 1000};
        bv = '{-600, -100, 200, 700};
        bp = '{900, -300, -800, 500};
        // Voltages go in increasing order
        for (int k = 0; k < 4; k++)
        begin
            wr(8'h10 + 8'(4 * k), {16'(ap[k]), 16'(av[k])});
            wr(8'h20 + 8'(4 * k), {16'(bp[k]), 16'(bv[k])});
        end
        wr(8'h10, 32'hfa24f830);
        rd(8'h10, 32'hfc18fc18);
        check({31'h0, hresp}, 32'h00000000);
        rd(8'h24, {16'(bp[1]), 16'(bv[1])});
        wr(8'h00, 32'h00000123);
        for (int x = -1000; x <= 1000; x += 250)
            smp(x, x, -x, jmp(interp(av, ap, x), 0, 5), jmp(interp(bv, bp, x), 0, 5),
                jmp(interp(bv, bp, -x), 0, 5));
        smp(-200, -200, 200, 100, -60, -800);
        for (int c = 0; c < 5; c++)
        begin
            wr(8'h00, {23'h000000, 3'(c), 3'(c), 3'(c)});
            smp(-300, 250, 820, c > 3 ? interp(bv, bp, -300) : c > 2 ? interp(av, ap, -300) : 0,
                c > 3 ? interp(bv, bp, 250) : c > 2 ? interp(av, ap, 250) : 250,
                c > 3 ? interp(bv, bp, 820) : c > 2 ? interp(av, ap, 820) : 820);
        end
        wr(8'h00, 32'h000000df);
        rd(8'h00, 32'h000000dc);
    endtask

    task automatic t_jump();
        wr(8'h00, 32'h00000000);
        wr(8'h30, 32'h000a01f4);
        wr(8'h34, 32'hfffb07d0);
        rd(8'h34, 32'h000003e8);
        smp(490, 4, 5, 500, 4, 0);
        rd(8'h40, 32'h01ea01f4);
        smp(510, 999, 6, 500, 999, 6);
        smp(511, 0, 1000, 511, 0, 1000);
        smp(489, 1000, -4, 489, 1000, 0);
    endtask

    initial
    begin
        bad_count = 0;
        checks = 0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = aicm_pkg::HSIZE_WORD;
        hwdata = 32'h00000000;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_line();
        t_curves();
        t_jump();
        close_out();
    end
endmodule

`default_nettype wire
